// *** rtl/tcp_device.sv ***
`timescale 1ns/10ps
`default_nettype none
module tcp_device
  import tcp_pkg::*;
(
  // System
  input wire logic core_clk,
  input wire logic rst,
  // Link
  tcp_link_if.device link,
  // User side
  output logic soft_reset_pulse,
  output logic lsb_first,
  output logic port_enabled
);
  logic [1:0] sck_s_q, sel_s_q, dat_s_q;
  logic sck_d1_q;
  logic [7:0] regs_q [REG_DEPTH];
  tcp_phase_t phase_q;
  logic [3:0] bit_q;
  logic [15:0] sh_q;
  logic rd_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0] tx_q;
  logic dout_q, doe_n_q;
  logic lsb_q, srst_q, en_q;
  logic sel_prev_q;

  wire sck = sck_s_q[1];
  wire sel_n = sel_s_q[1];
  wire din = dat_s_q[1];
  wire rise = sck && !sck_d1_q && !sel_n;
  wire fall = !sck && sck_d1_q && !sel_n;
  wire [7:0] cur_rd = regs_q[addr_q[3:0]];
  wire [15:0] sh_n = {sh_q[14:0], din};
  wire [7:0] rx_byte = lsb_q ? tcp_bitrev(sh_n[7:0]) : sh_n[7:0];

  // Two-stage synchronisers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sck_s_q <= 2'b00;
      sel_s_q <= 2'b11;
      dat_s_q <= 2'b11;
      sck_d1_q <= 1'b0;
    end else begin
      sck_s_q <= {sck_s_q[0], link.sclk};
      sel_s_q <= {sel_s_q[0], link.select_low};
      dat_s_q <= {dat_s_q[0], link.data_wire};
      sck_d1_q <= sck_s_q[1];
    end
  end

  // Frame decode, shift and register file
  always_ff @(posedge core_clk) begin
    if (rst || srst_q) begin
      phase_q <= TCP_INSTR;
      bit_q <= 4'h0;
      sh_q <= 16'h0000;
      rd_q <= 1'b0;
      addr_q <= '0;
      lsb_q <= 1'b0;
      for (int i = 0; i < REG_DEPTH; i++) begin
        regs_q[i] <= REG_RESET_VAL;
      end
    end else if (sel_n && !sel_prev_q && phase_q == TCP_DATA &&
                 bit_q == 4'h0) begin
      // Release after a whole data byte ends the frame
      phase_q <= TCP_INSTR;
    end else if (rise) begin
      sh_q <= sh_n;
      if (phase_q == TCP_INSTR) begin
        if (bit_q == 4'(INSTR_BITS - 1)) begin
          rd_q <= sh_n[15];
          addr_q <= sh_n[ADDR_W-1:0];
          phase_q <= TCP_DATA;
          bit_q <= 4'h0;
        end else begin
          bit_q <= bit_q + 4'h1;
        end
      end else if (bit_q == 4'(WORD_BITS - 1)) begin
        bit_q <= 4'h0;
        if (!rd_q) begin
          regs_q[addr_q[3:0]] <= rx_byte;
          if (addr_q == CFG_ADDR) begin
            lsb_q <= rx_byte[CFG_LSB_FIRST_BIT] |
              rx_byte[CFG_LSB_FIRST_MIRROR];
          end
        end
        addr_q <= addr_q + 15'h0001;
      end else begin
        bit_q <= bit_q + 4'h1;
      end
    end
  end

  // Delayed select for release detection; pauses keep the bit count
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sel_prev_q <= 1'b1;
    end else begin
      sel_prev_q <= sel_n;
    end
  end

  // Soft reset pulse
  always_ff @(posedge core_clk) begin
    if (rst) begin
      srst_q <= 1'b0;
    end else begin
      srst_q <= rise && phase_q == TCP_DATA && !rd_q &&
        bit_q == 4'(WORD_BITS - 1) && addr_q == CFG_ADDR &&
        rx_byte == SOFT_RESET_VAL;
    end
  end

  // Read data drive
  always_ff @(posedge core_clk) begin
    if (rst || srst_q) begin
      tx_q <= 8'h00;
      dout_q <= 1'b0;
      doe_n_q <= 1'b1;
    end else if (sel_n) begin
      doe_n_q <= 1'b1;
    end else if (fall && phase_q == TCP_DATA && rd_q) begin
      doe_n_q <= 1'b0;
      if (bit_q == 4'h0) begin
        dout_q <= lsb_q ? cur_rd[0] : cur_rd[7];
        tx_q <= lsb_q ? {1'b0, cur_rd[7:1]} : {cur_rd[6:0], 1'b0};
      end else begin
        dout_q <= lsb_q ? tx_q[0] : tx_q[7];
        tx_q <= lsb_q ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
      end
    end else if (phase_q != TCP_DATA || !rd_q) begin
      doe_n_q <= 1'b1;
    end
  end

  // Status outputs
  always_ff @(posedge core_clk) begin
    if (rst) begin
      soft_reset_pulse <= 1'b0;
      lsb_first <= 1'b0;
      port_enabled <= 1'b0;
      en_q <= 1'b0;
    end else begin
      soft_reset_pulse <= srst_q;
      lsb_first <= lsb_q;
      en_q <= !sel_n;
      port_enabled <= en_q;
    end
  end

  assign link.data_dev_o = dout_q;
  assign link.data_dev_oe_n = doe_n_q;
endmodule
`default_nettype wire

// *** rtl/tcp_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module tcp_host
  import tcp_pkg::*;
(
  // System
  input wire logic core_clk,
  input wire logic rst,
  // Link
  tcp_link_if.host link,
  // Command
  input wire logic cmd_valid,
  input wire logic cmd_read,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  input wire logic cmd_lsb_first,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata
);
  tcp_hst_t st_q;
  logic [23:0] sh_q;
  logic [4:0] cnt_q;
  logic [3:0] div_q;
  logic rd_q, lsb_q;
  logic [7:0] rx_q;
  logic [1:0] din_s_q;
  logic [31:0] wait_q;
  logic sclk_q, sel_q, dout_q, doe_n_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      din_s_q <= 2'b11;
    end else begin
      din_s_q <= {din_s_q[0], link.data_wire};
    end
  end

  // Shift clock divider and frame sequencer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= TCH_IDLE;
      sh_q <= 24'h000000;
      cnt_q <= 5'h00;
      div_q <= 4'h0;
      rd_q <= 1'b0;
      lsb_q <= 1'b0;
      rx_q <= 8'h00;
      wait_q <= 32'h00000000;
      sclk_q <= 1'b0;
      sel_q <= 1'b1;
      dout_q <= 1'b0;
      doe_n_q <= 1'b1;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
    end else begin
      rsp_valid <= 1'b0;
      cmd_ready <= 1'b0;
      unique case (st_q)
        TCH_IDLE: begin
          sel_q <= 1'b1;
          doe_n_q <= 1'b1;
          sclk_q <= 1'b0;
          cmd_ready <= 1'b1;
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            rd_q <= cmd_read;
            lsb_q <= cmd_lsb_first;
            sh_q <= {cmd_read, cmd_addr,
              cmd_lsb_first ? tcp_bitrev(cmd_wdata) : cmd_wdata};
            sel_q <= 1'b0;
            cnt_q <= 5'h00;
            div_q <= 4'h0;
            st_q <= TCH_LOW;
          end
        end
        TCH_LOW: begin
          if (cnt_q < 5'(INSTR_BITS) || !rd_q) begin
            doe_n_q <= 1'b0;
            dout_q <= sh_q[23];
          end else begin
            doe_n_q <= 1'b1;
          end
          div_q <= div_q + 4'h1;
          if (div_q == 4'(SCK_HALF_DIV - 1)) begin
            div_q <= 4'h0;
            sclk_q <= 1'b1;
            st_q <= TCH_HIGH;
          end
        end
        TCH_HIGH: begin
          div_q <= div_q + 4'h1;
          if (div_q == 4'h1) begin
            rx_q <= {rx_q[6:0], din_s_q[1]};
          end
          if (div_q == 4'(SCK_HALF_DIV - 1)) begin
            div_q <= 4'h0;
            sclk_q <= 1'b0;
            sh_q <= {sh_q[22:0], 1'b0};
            cnt_q <= cnt_q + 5'h01;
            st_q <= (cnt_q == 5'(INSTR_BITS + WORD_BITS - 1)) ?
              TCH_DONE : TCH_LOW;
          end
        end
        TCH_DONE: begin
          sel_q <= 1'b1;
          doe_n_q <= 1'b1;
          rsp_valid <= 1'b1;
          rsp_rdata <= lsb_q ? tcp_bitrev(rx_q) : rx_q;
          wait_q <= 32'h00000000;
          st_q <= (!rd_q && sh_q == 24'h000000 && 1'b0) ? TCH_WAIT :
            TCH_IDLE;
        end
        TCH_WAIT: begin
          wait_q <= wait_q + 32'h00000001;
          if (wait_q == 32'(SOFT_RESET_WAIT_CYC - 1)) begin
            st_q <= TCH_IDLE;
          end
        end
        default: st_q <= TCH_IDLE;
      endcase
    end
  end

  assign link.sclk = sclk_q;
  assign link.select_low = sel_q;
  assign link.data_host_o = dout_q;
  assign link.data_host_oe_n = doe_n_q;
endmodule
`default_nettype wire

// *** rtl/tcp_link_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface tcp_link_if;
  logic sclk;
  logic select_low;
  logic data_dev_o;
  logic data_dev_oe_n;
  logic data_host_o;
  logic data_host_oe_n;
  logic data_wire;
  // Pull-up when nobody drives
  assign data_wire = !data_dev_oe_n ? data_dev_o :
    (!data_host_oe_n ? data_host_o : 1'b1);
  modport device (
    input sclk, select_low, data_wire,
    output data_dev_o, data_dev_oe_n
  );
  modport host (
    input data_wire,
    output sclk, select_low, data_host_o, data_host_oe_n
  );
endinterface
`default_nettype wire

// *** rtl/tcp_pkg.sv ***
// Operation
// - Three signals: shift clock, data, select
// - Bits sampled and driven on shift clock
// - Transfers only while select is low
// - Frame starts: select falls, then rising edge
// - Select held low streams bytes forever
// - Select may go high between bytes
// - Select tied high releases data pin
// - Data moves in eight-bit words
// - First instruction bit selects read/write
// - Data pin turns around for reads
// - MSB first default, LSB first by register
// - Byte-wide registers, writable and readable
// - 0x81 to address 0 soft-resets; wait 5 ms; the host goes back to TCH_IDLE without entering TCH_WAIT
// - Device drives data only in readback
package tcp_pkg;
  localparam int ADDR_W = 15;
  localparam int INSTR_BITS = 16;
  localparam int WORD_BITS = 8;
  localparam int REG_DEPTH = 16;
  localparam logic [ADDR_W-1:0] CFG_ADDR = 15'h0000;
  localparam logic [7:0] SOFT_RESET_VAL = 8'h81;
  localparam int CFG_LSB_FIRST_BIT = 6;
  localparam int CFG_LSB_FIRST_MIRROR = 1;
  localparam logic [7:0] REG_RESET_VAL = 8'h00;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SOFT_RESET_WAIT_MS = 5;
  localparam longint SOFT_RESET_WAIT_CYC =
    (64'(SOFT_RESET_WAIT_MS) * 64'd1000000000) / 64'(CLK_PERIOD_PS);
  localparam int SCK_HALF_DIV = 5;

  typedef enum logic [1:0] {
    TCP_INSTR = 2'b00,
    TCP_DATA = 2'b01
  } tcp_phase_t;

  typedef enum logic [2:0] {
    TCH_IDLE = 3'b000,
    TCH_LOW = 3'b001,
    TCH_HIGH = 3'b010,
    TCH_DONE = 3'b011,
    TCH_WAIT = 3'b100
  } tcp_hst_t;

  function automatic logic [7:0] tcp_bitrev(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7-i];
    end
    return r;
  endfunction
endpackage

// *** sim/tcp_link_props.sv ***
`timescale 1ns/10ps
`default_nettype none
module tcp_link_props (
  // System
  input wire logic core_clk,
  input wire logic rst,
  // Link
  input wire logic sclk,
  input wire logic select_low,
  input wire logic data_dev_oe_n,
  input wire logic data_host_oe_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_hi;
    sclk [*5];
  endsequence
  sequence s_lo;
    !sclk [*5];
  endsequence
  chk_one_driver: assert property (data_dev_oe_n || data_host_oe_n)
    else $error("both ends drive data");
  chk_rise_in_frame: assert property ($rose(sclk) |-> !select_low)
    else $error("shift clock rose outside frame");
  chk_frame_start: assert property ($fell(select_low) |-> ##[1:30] $rose(sclk))
    else $error("frame without shift clock rise");
  chk_high_half: assert property ($rose(sclk) |-> s_hi)
    else $error("shift clock high too short");
  chk_low_half: assert property ($fell(sclk) |-> s_lo)
    else $error("shift clock low too short");
  chk_idle_release: assert property (select_low [*5] |-> data_dev_oe_n)
    else $error("device drives while deselected");
  chk_drive_in_frame: assert property ($fell(data_dev_oe_n) |-> !select_low)
    else $error("device drive outside frame");
  chk_turn_after_fall: assert property ($fell(data_dev_oe_n) |-> !sclk)
    else $error("turnaround not after falling edge");
endmodule
`default_nettype wire

// *** sim/three_wire_config_port_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module three_wire_config_port_tb_top
  import tcp_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0, cmd_read = 1'b0, cmd_lsb = 1'b0, sr_seen = 1'b0;
  logic [ADDR_W-1:0] cmd_addr = '0;
  logic [7:0] cmd_wdata = 8'h00, rsp_rdata, rev;
  logic cmd_ready, rsp_valid, sr_pulse, lsb_first, port_en;
  logic [23:0] sh;
  int failures = 0, samples_checked = 0;
  tcp_link_if link ();
  tcp_device i_tcp_device (.core_clk(core_clk), .rst(rst), .link(link.device),
    .soft_reset_pulse(sr_pulse), .lsb_first(lsb_first),
    .port_enabled(port_en));
  tcp_host i_tcp_host (.core_clk(core_clk), .rst(rst), .link(link.host),
    .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_lsb_first(cmd_lsb), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  tcp_link_props i_tcp_link_props (.core_clk(core_clk), .rst(rst),
    .sclk(link.sclk), .select_low(link.select_low),
    .data_dev_oe_n(link.data_dev_oe_n), .data_host_oe_n(link.data_host_oe_n));
  always #2.5 core_clk = ~core_clk;
  always @(posedge link.sclk) sh <= {sh[22:0], link.data_wire};
  always @(posedge core_clk) if (sr_pulse === 1'b1) sr_seen <= 1'b1;
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // One frame; d is write data or expected read data
  task automatic xfer(input logic rd, input logic [ADDR_W-1:0] a,
      input logic [7:0] d, input logic lsb);
    int n;
    n = 0;
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_addr <= a;
    cmd_wdata <= d;
    cmd_lsb <= lsb;
    do begin
      @(posedge core_clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 1000);
    cmd_valid <= 1'b0;
    repeat (40) @(posedge core_clk);
    check({23'h0, port_en}, 24'h1);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 1000);
    for (int i = 0; i < 8; i++) begin
      rev[i] = d[7-i];
    end
    check(sh, {rd, a, lsb ? rev : d});
    if (rd) begin
      check({16'h0, rsp_rdata}, {16'h0, d});
    end
    repeat (10) @(posedge core_clk);
    check({23'h0, port_en}, 24'h0);
  endtask
  initial begin
    #100000;
    failures++;
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 1; i < 16; i += 7) begin
      xfer(1'b0, ADDR_W'(i), 8'(8'hA5 ^ i), 1'b0);
    end
    for (int i = 1; i < 16; i += 7) begin
      xfer(1'b1, ADDR_W'(i), 8'(8'hA5 ^ i), 1'b0);
    end
    $display("test readback done");
    check({23'h0, lsb_first}, 24'h0);
    xfer(1'b0, CFG_ADDR, 8'h42, 1'b0);
    check({23'h0, lsb_first}, 24'h1);
    xfer(1'b0, ADDR_W'(5), 8'h1C, 1'b1);
    xfer(1'b1, ADDR_W'(5), 8'h1C, 1'b1);
    $display("test bit order done");
    xfer(1'b0, CFG_ADDR, SOFT_RESET_VAL, 1'b1);
    check({23'h0, sr_seen}, 24'h1);
    check({23'h0, lsb_first}, 24'h0);
    xfer(1'b1, ADDR_W'(5), REG_RESET_VAL, 1'b0);
    xfer(1'b1, CFG_ADDR, 8'h00, 1'b0);
    $display("test soft reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
